// *** core/dsc_ahb_slave.sv ***
// AHB-Lite slave front end: zero-wait writes, one-wait reads
module dsc_ahb_slave
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // AHB-Lite
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Register side
    output logic wr_en_o,
    output logic [11:0] reg_idx_o,
    output logic [31:0] wr_data_o,
    input wire logic [31:0] rd_data_i
);

    logic wr_pend_d;
    logic wr_pend_q;
    logic rd_wait_d;
    logic rd_wait_q;
    logic [11:0] idx_d;
    logic [11:0] idx_q;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic take;

    always_comb
    begin
        take = hsel_i && hready_i && (htrans_i == dsc_pkg::HTRANS_NONSEQ);
        wr_pend_d = take && hwrite_i;
        rd_wait_d = take && !hwrite_i;
        idx_d = take ? haddr_i[dsc_pkg::IDX_MSB:dsc_pkg::IDX_LSB] : idx_q;
        // Read data sampled one cycle into the data phase so a prior write is seen
        rdata_d = rd_wait_q ? rd_data_i : rdata_q;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_pend_q <= 1'b0;
            rd_wait_q <= 1'b0;
            idx_q <= 12'h000;
            rdata_q <= dsc_pkg::RDATA_ZERO;
        end
        else
        begin
            wr_pend_q <= wr_pend_d;
            rd_wait_q <= rd_wait_d;
            idx_q <= idx_d;
            rdata_q <= rdata_d;
        end
    end

    assign hreadyout_o = !rd_wait_q;
    assign hresp_o = dsc_pkg::HRESP_OKAY;
    assign hrdata_o = rdata_q;
    assign wr_en_o = wr_pend_q;
    assign reg_idx_o = idx_q;
    assign wr_data_o = hwdata_i;

endmodule // dsc_ahb_slave

// *** core/dsc_comparator.sv ***
// Comparator A match qualification on monitored processor bus cycles
module dsc_comparator
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Configuration
    input wire logic [7:0] ctrl_i,
    // Monitored cycle
    input wire logic cyc_valid_i,
    input wire logic cyc_fetch_i,
    input wire logic cyc_rw_i,
    input wire logic cyc_addr_match_i,
    input wire logic cyc_data_match_i,
    // Result
    output logic match_o
);

    logic match_d;
    logic match_q;
    logic dir_ok;
    logic data_ok;

    always_comb
    begin
        dir_ok = !ctrl_i[dsc_pkg::RWE_BIT] || (cyc_rw_i == ctrl_i[dsc_pkg::RWV_BIT]);
        data_ok = cyc_data_match_i ^ ctrl_i[dsc_pkg::NDB_BIT];
        match_d = 1'b0;
        if (ctrl_i[dsc_pkg::COMPARATOR_ENABLE_BIT] && cyc_valid_i && cyc_addr_match_i)
        begin
            if (ctrl_i[dsc_pkg::INSTRUCTION_FETCH_SELECT_BIT])
            begin
                match_d = cyc_fetch_i;
            end
            else
            begin
                match_d = !cyc_fetch_i && dir_ok && data_ok;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            match_q <= 1'b0;
        end
        else
        begin
            match_q <= match_d;
        end
    end

    assign match_o = match_q;

endmodule // dsc_comparator

// *** core/dsc_top.sv ***
// Debug session status register and comparator A control with AHB-Lite access
module dsc_top
(
    // Clock and resets
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic por_n_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Monitored processor bus cycle
    input wire logic cyc_valid_i,
    input wire logic cyc_fetch_i,
    input wire logic cyc_rw_i,
    input wire logic cyc_addr_match_i,
    input wire logic cyc_data_match_i,
    output logic comp_a_match_o,
    // Sequencer and trace events
    input wire logic seq_step_i,
    input wire logic [2:0] seq_target_i,
    input wire logic session_end_i,
    input wire logic trace_full_i,
    input wire logic prof_start_i,
    input wire logic prof_end_i,
    // Session state
    output logic armed_o,
    output logic [2:0] seq_state_o
);

    logic rst_meta_q;
    logic rst_n_q;
    logic por_meta_q;
    logic por_n_q;

    // Bus side register strobes
    logic wr_en;
    logic [11:0] reg_idx;
    logic [31:0] wr_data;
    logic [31:0] rd_data;
    logic wr_ctl_one;
    logic wr_ctrl_a;
    logic arm_write;
    logic disarm_write;
    logic ctrl_a_open;

    // Session, profiling and control state
    logic armed_d;
    logic armed_q;
    dsc_pkg::dsc_state_t state_d;
    dsc_pkg::dsc_state_t state_q;
    logic profiling_active_flag_d;
    logic profiling_active_flag_q;
    logic [7:0] ctrl_a_d;
    logic [7:0] ctrl_a_q;
    logic tbf_d;
    logic tbf_q;

    // Index compare shared by the read and write decoders
    function automatic logic reg_hit(input logic [11:0] idx, input logic [11:0] target);
        return idx == target;
    endfunction

    // Reset release through two flip-flops, system reset includes power-on
    always_ff @(posedge clk_i or negedge reset_n_i or negedge por_n_i)
    begin
        if (!reset_n_i || !por_n_i)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // Power-on release, kept apart so the full flag survives system resets
    always_ff @(posedge clk_i or negedge por_n_i)
    begin
        if (!por_n_i)
        begin
            por_meta_q <= 1'b0;
            por_n_q <= 1'b0;
        end
        else
        begin
            por_meta_q <= 1'b1;
            por_n_q <= por_meta_q;
        end
    end

    // Register bus front end; reads take one wait state
    dsc_ahb_slave u_bus
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_q),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hsize_i(hsize_i),
        .hwdata_i(hwdata_i),
        .hready_i(hready_i),
        .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o),
        .wr_en_o(wr_en),
        .reg_idx_o(reg_idx),
        .wr_data_o(wr_data),
        .rd_data_i(rd_data)
    );

    // Comparator A works from the registered control word
    dsc_comparator u_comp_a
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_q),
        .ctrl_i(ctrl_a_q),
        .cyc_valid_i(cyc_valid_i),
        .cyc_fetch_i(cyc_fetch_i),
        .cyc_rw_i(cyc_rw_i),
        .cyc_addr_match_i(cyc_addr_match_i),
        .cyc_data_match_i(cyc_data_match_i),
        .match_o(comp_a_match_o)
    );

    // Write decode
    always_comb
    begin
        wr_ctl_one = 1'b0;
        wr_ctrl_a = 1'b0;
        if (wr_en && reg_hit(reg_idx, dsc_pkg::CONTROL_ONE_IDX))
        begin
            wr_ctl_one = 1'b1;
        end
        else if (wr_en && reg_hit(reg_idx, dsc_pkg::CTRL_A_IDX))
        begin
            wr_ctrl_a = 1'b1;
        end
        arm_write = wr_ctl_one && wr_data[dsc_pkg::ARM_BIT];
        disarm_write = wr_ctl_one && !wr_data[dsc_pkg::ARM_BIT];
        ctrl_a_open = !armed_q && !profiling_active_flag_q;
    end

    // Read decode
    always_comb
    begin
        // Unmapped indices and unused bits read as zero
        rd_data = dsc_pkg::RDATA_ZERO;
        if (reg_hit(reg_idx, dsc_pkg::STATUS_IDX))
        begin
            rd_data[dsc_pkg::TBF_BIT] = tbf_q;
            rd_data[dsc_pkg::PROFILING_ACTIVE_FLAG_BIT] = profiling_active_flag_q;
            rd_data[dsc_pkg::SSF_MSB:dsc_pkg::SSF_LSB] = state_q;
        end
        else if (reg_hit(reg_idx, dsc_pkg::CTRL_A_IDX))
        begin
            rd_data[7:0] = ctrl_a_q;
        end
        else if (reg_hit(reg_idx, dsc_pkg::CONTROL_ONE_IDX))
        begin
            rd_data[dsc_pkg::ARM_BIT] = armed_q;
        end
    end

    // Session and sequencer next state
    // Priority: arm write, disarm write, internal end, then step
    always_comb
    begin
        armed_d = armed_q;
        state_d = state_q;
        if (arm_write)
        begin
            armed_d = 1'b1;
            state_d = dsc_pkg::DSC_ST_ONE;
        end
        else if (disarm_write)
        begin
            armed_d = 1'b0;
        end
        else if (armed_q && session_end_i)
        begin
            armed_d = 1'b0;
            state_d = dsc_pkg::DSC_ST_DISARMED;
        end
        else if (armed_q && seq_step_i)
        begin
            case (seq_target_i)
                dsc_pkg::DSC_ST_ONE: state_d = dsc_pkg::DSC_ST_ONE;
                dsc_pkg::DSC_ST_TWO: state_d = dsc_pkg::DSC_ST_TWO;
                dsc_pkg::DSC_ST_THREE: state_d = dsc_pkg::DSC_ST_THREE;
                dsc_pkg::DSC_ST_FINAL: state_d = dsc_pkg::DSC_ST_FINAL;
                default: state_d = state_q;
            endcase
        end
    end

    // Profiling flag next state; a start in the same cycle as an end wins
    always_comb
    begin
        profiling_active_flag_d = profiling_active_flag_q;
        if (prof_end_i)
        begin
            profiling_active_flag_d = 1'b0;
        end
        if (prof_start_i)
        begin
            profiling_active_flag_d = 1'b1;
        end
    end

    // Comparator A control next state
    always_comb
    begin
        ctrl_a_d = ctrl_a_q;
        // write lock while armed or profiling
        if (wr_ctrl_a && ctrl_a_open)
        begin
            ctrl_a_d = wr_data[7:0] & dsc_pkg::CTRL_A_MASK;
        end
    end

    // Trace buffer full next state
    always_comb
    begin
        tbf_d = tbf_q;
        if (arm_write)
        begin
            tbf_d = 1'b0;
        end
        // set by buffer fill, wins over clear
        if (trace_full_i)
        begin
            tbf_d = 1'b1;
        end
    end

    // Session registers
    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            armed_q <= 1'b0;
            state_q <= dsc_pkg::DSC_ST_DISARMED;
        end
        else
        begin
            armed_q <= armed_d;
            state_q <= state_d;
        end
    end

    // Profiling flag register
    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            profiling_active_flag_q <= 1'b0;
        end
        else
        begin
            profiling_active_flag_q <= profiling_active_flag_d;
        end
    end

    // Comparator A control register
    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            ctrl_a_q <= dsc_pkg::CTRL_A_RESET;
        end
        else
        begin
            ctrl_a_q <= ctrl_a_d;
        end
    end

    always_ff @(posedge clk_i or negedge por_n_q)
    begin
        if (!por_n_q)
        begin
            tbf_q <= 1'b0;
        end
        else
        begin
            tbf_q <= tbf_d;
        end
    end

    assign armed_o = armed_q;
    assign seq_state_o = state_q;

endmodule // dsc_top

// *** inc/dsc_pkg.sv ***
// Shared constants and types for the debug status and comparator A block
package dsc_pkg;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [11:0] STATUS_IDX = 12'h10B;
    localparam logic [11:0] CTRL_A_IDX = 12'h110;
    localparam logic [11:0] CONTROL_ONE_IDX = 12'h100;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 13;

    // Status register fields
    localparam int TBF_BIT = 7;
    localparam int PROFILING_ACTIVE_FLAG_BIT = 4;
    localparam int SSF_LSB = 0;
    localparam int SSF_MSB = 2;

    // Comparator A control fields
    localparam int NDB_BIT = 6;
    localparam int INSTRUCTION_FETCH_SELECT_BIT = 5;
    localparam int RWV_BIT = 3;
    localparam int RWE_BIT = 2;
    localparam int COMPARATOR_ENABLE_BIT = 0;
    localparam logic [7:0] CTRL_A_MASK = 8'h6D;
    localparam logic [7:0] CTRL_A_RESET = 8'h00;

    // Control-one register field
    localparam int ARM_BIT = 7;

    // Bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;
    localparam logic [31:0] RDATA_ZERO = 32'h00000000;

    typedef enum logic [2:0]
    {
        DSC_ST_DISARMED = 3'b000,
        DSC_ST_ONE = 3'b001,
        DSC_ST_TWO = 3'b010,
        DSC_ST_THREE = 3'b011,
        DSC_ST_FINAL = 3'b100
    } dsc_state_t;

endpackage

// *** tb/dsc_cpu_model.sv ***
// Model of the monitored processor bus issuing single cycles
module dsc_cpu_model
(
    // Clock
    input wire logic clk_i,
    // Monitored cycle
    output logic valid_o,
    output logic fetch_o,
    output logic rw_o,
    output logic am_o,
    output logic dm_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        valid_o = 1'b0;
        {fetch_o, rw_o, am_o, dm_o} = 4'h0;
    end
    // One cycle of {fetch, rw, addr match, data match}; lines flip once released
    task automatic cyc(input logic [3:0] k);
        @(posedge clk_i);
        valid_o <= 1'b1;
        {fetch_o, rw_o, am_o, dm_o} <= k;
        @(posedge clk_i);
        valid_o <= 1'b0;
        {fetch_o, rw_o, am_o, dm_o} <= ~k;
    endtask
endmodule // dsc_cpu_model

// *** tb/dsc_top_sva.sv ***
// Assertion checker on the ports of the status and comparator A block
module dsc_top_sva
(
    // Clock and resets
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic por_n_i,
    // Bus
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    // Monitor
    input wire logic cyc_valid_i,
    input wire logic cyc_addr_match_i,
    input wire logic comp_a_match_o,
    // Sequencer
    input wire logic seq_step_i,
    input wire logic [2:0] seq_target_i,
    input wire logic session_end_i,
    input wire logic armed_o,
    input wire logic [2:0] seq_state_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i || !por_n_i);
    logic take;
    logic wr_ph_d;
    logic wr_ph_q;
    assign take = hsel_i && hready_i && htrans_i == dsc_pkg::HTRANS_NONSEQ;
    assign wr_ph_d = take && hwrite_i;
    // Marks the data phase of a write, when a register commits
    always_ff @(posedge clk_i or negedge por_n_i)
    begin
        if (!por_n_i)
        begin
            wr_ph_q <= 1'b0;
        end
        else
        begin
            wr_ph_q <= wr_ph_d;
        end
    end
    sequence s_rd_wait;
        !hreadyout_o ##1 hreadyout_o;
    endsequence
    property p_rd_wait;
        take && !hwrite_i |=> s_rd_wait;
    endproperty
    a_rd_wait: assert property (p_rd_wait)
        else $error("read wait state wrong");
    property p_wr_rdy;
        wr_ph_d |=> hreadyout_o;
    endproperty
    a_wr_rdy: assert property (p_wr_rdy)
        else $error("write stalled");
    property p_match;
        comp_a_match_o |-> $past(cyc_valid_i && cyc_addr_match_i);
    endproperty
    a_match: assert property (p_match)
        else $error("match without qualifying cycle");
    property p_enc;
        seq_state_o inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
    endproperty
    a_enc: assert property (p_enc)
        else $error("reserved state code");
    property p_arm;
        $rose(armed_o) |-> seq_state_o == 3'h1;
    endproperty
    a_arm: assert property (p_arm)
        else $error("arming state wrong");
    property p_step;
        armed_o && seq_step_i && seq_target_i inside {[3'h1:3'h4]} && !session_end_i
            && !wr_ph_q |=> seq_state_o == $past(seq_target_i);
    endproperty
    a_step: assert property (p_step)
        else $error("state not updated");
    property p_end;
        armed_o && session_end_i && !wr_ph_q |=> !armed_o && seq_state_o == 3'h0;
    endproperty
    a_end: assert property (p_end)
        else $error("session end wrong");
    property p_keep;
        $fell(armed_o) && !$past(session_end_i) |-> $stable(seq_state_o);
    endproperty
    a_keep: assert property (p_keep)
        else $error("disarm changed state");
endmodule // dsc_top_sva

bind dsc_top dsc_top_sva dsc_top_sva_i
(
    .clk_i(clk_i), .reset_n_i(reset_n_i), .por_n_i(por_n_i), .hsel_i(hsel_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
    .cyc_valid_i(cyc_valid_i), .cyc_addr_match_i(cyc_addr_match_i),
    .comp_a_match_o(comp_a_match_o), .seq_step_i(seq_step_i), .seq_target_i(seq_target_i),
    .session_end_i(session_end_i), .armed_o(armed_o), .seq_state_o(seq_state_o)
);

// *** tb/dsc_top_tb.sv ***
// Testbench for the status and comparator A block
`define CHK(g, e) \
    begin \
        n_checks++; \
        if ((g) !== (e)) \
        begin \
            bad_count++; \
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e); \
        end \
    end

module dsc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] ST = 32'h0000042C;
    localparam logic [31:0] CA = 32'h00000440;
    localparam logic [31:0] C1 = 32'h00000400;
    int bad_count = 0;
    int n_checks = 0;
    int i;
    logic clk_i = 1'b0;
    logic reset_n_i, por_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, comp_a_match_o;
    logic seq_step_i, session_end_i, trace_full_i, prof_start_i, prof_end_i, armed_o;
    logic cyc_valid_i, cyc_fetch_i, cyc_rw_i, cyc_addr_match_i, cyc_data_match_i;
    logic [31:0] haddr_i, hwdata_i, hrdata_o;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i, seq_target_i, seq_state_o;
    logic [12:0] tbl [14];
    wire hready_i = hreadyout_o;

    dsc_top dsc_top_i (.*);
    dsc_cpu_model dsc_cpu_model_i (.clk_i(clk_i), .valid_o(cyc_valid_i), .fetch_o(cyc_fetch_i),
        .rw_o(cyc_rw_i), .am_o(cyc_addr_match_i), .dm_o(cyc_data_match_i));

    initial
    begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        @(posedge clk_i);
        hsel_i <= 1'b1;
        haddr_i <= a;
        hwrite_i <= w;
        htrans_i <= dsc_pkg::HTRANS_NONSEQ;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        htrans_i <= 2'h0;
        hsel_i <= 1'b0;
        hwdata_i <= d;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        r = hrdata_o;
    endtask

    task automatic wr(input logic [31:0] a, d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask

    task automatic rdc(input logic [31:0] a, e);
        logic [31:0] x;
        xfer(1'b0, a, 32'h0, x);
        `CHK(x, e)
        `CHK(hresp_o, dsc_pkg::HRESP_OKAY)
    endtask

    // Pulse of {step, end, full, prof start, prof end}
    task automatic ev(input logic [4:0] e, input logic [2:0] t);
        @(posedge clk_i);
        {seq_step_i, session_end_i, trace_full_i, prof_start_i, prof_end_i} <= e;
        seq_target_i <= t;
        @(posedge clk_i);
        {seq_step_i, session_end_i, trace_full_i, prof_start_i, prof_end_i} <= 5'h0;
    endtask

    task automatic rst(input logic p);
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        por_n_i <= ~p;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        por_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #200000;
        bad_count++;
        wrap_up;
    end

    initial
    begin
        {reset_n_i, por_n_i, hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = '0;
        {seq_step_i, session_end_i, trace_full_i, prof_start_i, prof_end_i} = 5'h0;
        hsize_i = 3'h2;
        seq_target_i = 3'h0;
        // Entries of {control, fetch, rw, addr match, data match, expected}
        tbl = '{13'h02F, 13'h02C, 13'h82D, 13'h82E, 13'h00E, 13'h435, 13'h42E,
            13'hCBF, 13'h0A7, 13'h0AE, 13'h1AF, 13'h1A6, 13'h127, 13'h02A};
        rst(1'b1);
        rdc(ST, 32'h0);
        wr(ST, 32'hFF);
        rdc(ST, 32'h0);
        wr(32'h00000444, 32'hFF);
        rdc(32'h00000444, 32'h0);
        wr(CA, 32'hFF);
        rdc(CA, 32'h6D);
        $display("test registers done");
        for (i = 0; i < 14; i++)
        begin
            wr(CA, {24'h0, tbl[i][12:5]});
            dsc_cpu_model_i.cyc(tbl[i][4:1]);
            #1;
            `CHK(comp_a_match_o, tbl[i][0])
        end
        $display("test comparator done");
        wr(C1, 32'h80);
        rdc(ST, 32'h01);
        wr(CA, 32'h0);
        rdc(CA, 32'h01);
        for (i = 2; i <= 4; i++)
        begin
            ev(5'h10, 3'(i));
            rdc(ST, 32'(i));
        end
        ev(5'h10, 3'h5);
        rdc(ST, 32'h04);
        ev(5'h04, 3'h0);
        rdc(ST, 32'h84);
        wr(C1, 32'h0);
        rdc(ST, 32'h84);
        `CHK(seq_state_o, 3'h4)
        rst(1'b0);
        rdc(ST, 32'h80);
        wr(C1, 32'h80);
        rdc(ST, 32'h01);
        ev(5'h10, 3'h3);
        ev(5'h08, 3'h0);
        rdc(ST, 32'h0);
        `CHK(armed_o, 1'b0)
        `CHK(seq_state_o, 3'h0)
        wr(CA, 32'h05);
        ev(5'h02, 3'h0);
        rdc(ST, 32'h10);
        wr(CA, 32'h41);
        rdc(CA, 32'h05);
        ev(5'h01, 3'h0);
        rdc(ST, 32'h0);
        wr(CA, 32'h41);
        rdc(CA, 32'h41);
        wr(C1, 32'h80);
        ev(5'h04, 3'h0);
        rst(1'b1);
        rdc(ST, 32'h0);
        $display("test sequencer done");
        wrap_up;
    end
endmodule // dsc_top_tb
